// file: ibtg_guard.sv
// How it works
// - After our address byte we hold the clock low for a bounded stretch.
// - An inactivity timer runs between frames of one command.
// - The same timer runs between bytes inside one frame.
// - If the timer expires mid-command, a system reset is requested.
`timescale 1ns/1ns
module ibtg_guard #(
    parameter int unsigned TIMEOUT_CYCLES = ibtg_pkg::TIMEOUT_CYC
) (
    input wire logic clk, // Core clock, 20 MHz.
    input wire logic rst_n, // Synchronous reset, active low.
    input ibtg_pkg::ibtg_pins_t pin_i, // Raw clock and data pin levels.
    input wire logic [6:0] own_addr, // Our 7-bit bus address.
    input wire logic cmd_done, // Pulse from the boot logic: command finished.
    input wire logic erase_busy, // High while pages are being erased.
    output logic scl_o, // Clock pin output value.
    output logic scl_oe, // Clock pin output enable, high while stretching.
    output logic sda_o, // Data pin output value.
    output logic sda_oe, // Data pin output enable, high while acknowledging.
    output logic addressed, // High during a frame addressed to us.
    output logic rw_q, // Direction of the current frame, 1 is read.
    output logic byte_done_q, // Pulse: one byte of our frame completed.
    output logic [7:0] rx_data_q, // Last byte written to us.
    output logic rx_valid_q, // Pulse: rx_data_q holds a new written byte.
    output logic cmd_open_q, // High while a command is in progress.
    output logic sys_reset_req_q // Pulse: inactivity timeout, reset the system.
);
    import ibtg_pkg::*;

    ibtg_pins_t pin_s;
    ibtg_pins_t prev_q, prev_d;

    ibtg_state_t state_q, state_d;
    logic [3:0] bit_cnt_q, bit_cnt_d;
    logic [7:0] shift_q, shift_d;
    logic ack_q, ack_d;
    logic rw_d;
    logic [STRETCH_W-1:0] hold_cnt_q, hold_cnt_d;
    logic byte_done_d;
    logic [7:0] rx_data_d;
    logic rx_valid_d;

    logic cmd_open_d;
    logic [TMO_W-1:0] tmo_cnt_q, tmo_cnt_d;
    logic sys_reset_req_d;

    logic start_evt, stop_evt, scl_rise, scl_fall;
    logic byte_evt, expire;

    ibtg_sync u_sync (
        .clk(clk),
        .rst_n(rst_n),
        .pin_i(pin_i),
        .pin_o(pin_s)
    );

    // Bus conditions seen on the settled pin levels.
    assign start_evt = pin_s.scl && prev_q.scl && prev_q.sda && !pin_s.sda;
    assign stop_evt = pin_s.scl && prev_q.scl && !prev_q.sda && pin_s.sda;
    assign scl_rise = pin_s.scl && !prev_q.scl;
    assign scl_fall = !pin_s.scl && prev_q.scl;

    // A byte of a frame addressed to us has just completed.
    assign byte_evt = scl_fall && (bit_cnt_q == BIT_ACK) &&
                      ((state_q == DATA) || ((state_q == ADDR) && (shift_q[7:1] == own_addr)));

    // A byte arriving in the expiry cycle wins and restarts the timer.
    assign expire = cmd_open_q && !erase_busy && !byte_evt && !stop_evt &&
                    (tmo_cnt_q >= TMO_W'(TIMEOUT_CYCLES - 1));

    always_comb begin
        prev_d = pin_s;
        state_d = state_q;
        bit_cnt_d = bit_cnt_q;
        shift_d = shift_q;
        ack_d = ack_q;
        rw_d = rw_q;
        hold_cnt_d = hold_cnt_q;
        byte_done_d = 1'b0;
        rx_data_d = rx_data_q;
        rx_valid_d = 1'b0;
        if (expire) begin
            state_d = IDLE;
            ack_d = 1'b0;
            bit_cnt_d = BIT_ZERO;
        end else if (start_evt) begin
            state_d = ADDR;
            bit_cnt_d = BIT_ZERO;
            ack_d = 1'b0;
        end else if (stop_evt) begin
            state_d = IDLE;
            bit_cnt_d = BIT_ZERO;
            ack_d = 1'b0;
        end else begin
            case (state_q)
                IDLE: begin
                    bit_cnt_d = BIT_ZERO;
                end
                ADDR, DATA: begin
                    if (scl_rise && (bit_cnt_q != BIT_ACK)) begin
                        bit_cnt_d = bit_cnt_q + 4'h1;
                        if (bit_cnt_q != BIT_LAST_DATA) begin
                            shift_d = {shift_q[6:0], pin_s.sda};
                        end
                    end
                    if (scl_fall && (bit_cnt_q == BIT_LAST_DATA)) begin
                        // Acknowledge our address and every byte written to us.
                        if (state_q == ADDR) begin
                            ack_d = (shift_q[7:1] == own_addr);
                        end else begin
                            ack_d = !rw_q;
                        end
                    end
                    if (scl_fall && (bit_cnt_q == BIT_ACK)) begin
                        bit_cnt_d = BIT_ZERO;
                        ack_d = 1'b0;
                        if (state_q == ADDR) begin
                            if (shift_q[7:1] == own_addr) begin
                                rw_d = shift_q[0];
                                byte_done_d = 1'b1;
                                state_d = HOLD;
                                hold_cnt_d = STRETCH_W'(STRETCH_CYC - 1);
                            end else begin
                                state_d = SKIP;
                            end
                        end else begin
                            byte_done_d = 1'b1;
                            if (!rw_q) begin
                                rx_data_d = shift_q;
                                rx_valid_d = 1'b1;
                            end
                        end
                    end
                end
                HOLD: begin
                    // Clock held low; the host's connection wait covers this span.
                    if (hold_cnt_q == '0) begin
                        state_d = DATA;
                    end else begin
                        hold_cnt_d = hold_cnt_q - STRETCH_W'(1);
                    end
                end
                SKIP: begin
                    bit_cnt_d = BIT_ZERO;
                end
                default: begin
                    state_d = IDLE;
                end
            endcase
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            prev_q <= '{scl: PIN_IDLE, sda: PIN_IDLE};
            state_q <= IDLE;
            bit_cnt_q <= BIT_ZERO;
            shift_q <= SHIFT_RST;
            ack_q <= 1'b0;
            rw_q <= 1'b0;
            hold_cnt_q <= '0;
            byte_done_q <= 1'b0;
            rx_data_q <= SHIFT_RST;
            rx_valid_q <= 1'b0;
        end else begin
            prev_q <= prev_d;
            state_q <= state_d;
            bit_cnt_q <= bit_cnt_d;
            shift_q <= shift_d;
            ack_q <= ack_d;
            rw_q <= rw_d;
            hold_cnt_q <= hold_cnt_d;
            byte_done_q <= byte_done_d;
            rx_data_q <= rx_data_d;
            rx_valid_q <= rx_valid_d;
        end
    end

    // Inactivity timer for the command in progress.
    always_comb begin
        cmd_open_d = cmd_open_q;
        tmo_cnt_d = tmo_cnt_q;
        sys_reset_req_d = 1'b0;
        if (byte_evt) begin
            // A byte opens or continues a command, even if a finish arrives too.
            cmd_open_d = 1'b1;
            tmo_cnt_d = '0;
        end else if (expire) begin
            cmd_open_d = 1'b0;
            tmo_cnt_d = '0;
            sys_reset_req_d = 1'b1;
        end else if (cmd_done) begin
            cmd_open_d = 1'b0;
            tmo_cnt_d = '0;
        end else if (cmd_open_q && stop_evt) begin
            tmo_cnt_d = '0;
        end else if (cmd_open_q && !erase_busy) begin
            // Gaps between frames and between bytes are both timed here.
            tmo_cnt_d = tmo_cnt_q + TMO_W'(1);
        end else if (cmd_open_q) begin
            // Page erasure is the device's own work, not a host gap.
            tmo_cnt_d = '0;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            cmd_open_q <= 1'b0;
            tmo_cnt_q <= '0;
            sys_reset_req_q <= 1'b0;
        end else begin
            cmd_open_q <= cmd_open_d;
            tmo_cnt_q <= tmo_cnt_d;
            sys_reset_req_q <= sys_reset_req_d;
        end
    end

    // Both pins are open drain: only a low is ever driven.
    assign scl_o = 1'b0;
    assign scl_oe = (state_q == HOLD);
    assign sda_o = 1'b0;
    assign sda_oe = ack_q;
    assign addressed = (state_q == HOLD) || (state_q == DATA);

endmodule // ibtg_guard

// file: ibtg_guard_asserts.sv
`timescale 1ns/1ns
module ibtg_guard_asserts #(
    parameter int unsigned TIMEOUT_CYCLES = 200
) (
    input wire logic clk, // Clock.
    input wire logic rst_n, // Reset.
    input ibtg_pkg::ibtg_pins_t pin_i, // Pins.
    input wire logic cmd_done, // Command end.
    input wire logic erase_busy, // Erasing.
    input wire logic scl_oe, // Stretch.
    input wire logic addressed, // Our frame.
    input wire logic byte_done_q, // Byte end.
    input wire logic cmd_open_q, // Command open.
    input wire logic sys_reset_req_q // Timeout.
);
    import ibtg_pkg::*;
    logic [31:0] quiet_q, quiet_d;
    ibtg_pins_t pin_q, pin_d;
    // Cycles since anything that may restart the timer.
    always_comb begin
        pin_d = pin_i;
        quiet_d = quiet_q + 32'h1;
        if (byte_done_q || erase_busy || !cmd_open_q || pin_i != pin_q) begin
            quiet_d = 32'h0;
        end
    end
    always_ff @(posedge clk) begin
        if (!rst_n) begin
            quiet_q <= 32'h0;
            pin_q <= '1;
        end else begin
            quiet_q <= quiet_d;
            pin_q <= pin_d;
        end
    end
    default clocking @(posedge clk); endclocking
    default disable iff (!rst_n);
    sequence s_stretch_on;
        $rose(scl_oe);
    endsequence
    sequence s_stretch_off;
        ##[1:50] !scl_oe;
    endsequence
    a_stretch_bound: assert property (s_stretch_on |-> s_stretch_off)
        else $error("Stretch too long.");
    a_stretch_ours: assert property ($rose(scl_oe) |-> byte_done_q && addressed)
        else $error("Stretch outside our frame.");
    a_timeout_late: assert property (cmd_open_q |-> quiet_q < TIMEOUT_CYCLES + 8)
        else $error("Timeout missed.");
    a_timeout_early: assert property (sys_reset_req_q |-> quiet_q >= TIMEOUT_CYCLES - 4)
        else $error("Timeout too early.");
    a_reset_pulse: assert property (sys_reset_req_q |-> !cmd_open_q ##1 !sys_reset_req_q)
        else $error("Reset request not one closing pulse.");
    a_byte_opens: assert property (byte_done_q |-> cmd_open_q && !sys_reset_req_q)
        else $error("Byte did not restart timer.");
    a_done_stops: assert property (cmd_done ##1 !byte_done_q |-> !cmd_open_q)
        else $error("Command end did not stop timer.");
endmodule // ibtg_guard_asserts
bind ibtg_guard ibtg_guard_asserts #(.TIMEOUT_CYCLES(TIMEOUT_CYCLES)) u_ibtg_guard_asserts (
    .clk(clk), .rst_n(rst_n), .pin_i(pin_i), .cmd_done(cmd_done), .erase_busy(erase_busy), .scl_oe(scl_oe),
    .addressed(addressed), .byte_done_q(byte_done_q), .cmd_open_q(cmd_open_q), .sys_reset_req_q(sys_reset_req_q)
);

// file: ibtg_guard_tb.sv
`timescale 1ns/1ns
module ibtg_guard_tb;
    import ibtg_pkg::*;
    localparam int TO = 1000;
    typedef struct packed {
        logic [7:0] data;
        logic ack;
    } ibtg_row_t;
    ibtg_row_t rows [4] = '{'{8'h00, 1'h0}, '{8'hFF, 1'h0}, '{8'h80, 1'h0}, '{8'h01, 1'h0}};
    logic clk = 1'h0;
    logic rst_n = 1'h0;
    logic [6:0] own_addr = 7'h2A;
    logic cmd_done = 1'h0;
    logic erase_busy = 1'h0;
    ibtg_pins_t drv, bus;
    logic scl_o, scl_oe, sda_o, sda_oe, addressed, rw_q, byte_done_q, rx_valid_q, cmd_open_q, sys_reset_req_q;
    logic [7:0] rx_data_q;
    logic ack;
    logic got_rx = 1'h0;
    int errors = 0;
    int checked = 0;
    int cycles = 0;
    int stretch = 0;
    int pulses = 0;
    int dones = 0;
    int n;
    assign bus = {drv.scl & (scl_oe ? scl_o : 1'h1), drv.sda & (sda_oe ? sda_o : 1'h1)};
    ibtg_host u_ibtg_host (.clk(clk), .bus_i(bus), .drv_o(drv));
    ibtg_guard #(.TIMEOUT_CYCLES(TO)) u_ibtg_guard (
        .clk(clk), .rst_n(rst_n), .pin_i(bus), .own_addr(own_addr), .cmd_done(cmd_done), .erase_busy(erase_busy),
        .scl_o(scl_o), .scl_oe(scl_oe), .sda_o(sda_o), .sda_oe(sda_oe), .addressed(addressed), .rw_q(rw_q),
        .byte_done_q(byte_done_q), .rx_data_q(rx_data_q), .rx_valid_q(rx_valid_q), .cmd_open_q(cmd_open_q),
        .sys_reset_req_q(sys_reset_req_q)
    );
    initial begin
        forever #25 clk = ~clk;
    end
    task automatic complete_run();
        $display("Comparisons %0d, errors %0d", checked, errors);
        if (errors == 0 && checked > 0) begin
            $display("*** PASS ***");
        end else begin
            $display("*** FAIL ***");
        end
        $finish;
    endtask
    // Outputs are watched mid-cycle, where they have settled.
    always @(negedge clk) begin
        cycles++;
        if (scl_oe === 1'h1) stretch++;
        if (sys_reset_req_q === 1'h1) pulses++;
        if (byte_done_q === 1'h1) dones++;
        if (rx_valid_q === 1'h1) got_rx = 1'h1;
        if (cycles == 20000) begin
            errors++;
            complete_run();
        end
    end
    task automatic check(input logic [31:0] seen, input logic [31:0] exp);
        checked++;
        if (seen !== exp) begin
            errors++;
            $display("Error at %0t: seen %0h expected %0h", $time, seen, exp);
        end
    endtask
    task automatic wait_pulse(output int k);
        k = 0;
        while (sys_reset_req_q !== 1'h1 && k < 2 * TO) begin
            @(negedge clk);
            k++;
        end
    endtask
    task automatic open_frame();
        u_ibtg_host.start();
        u_ibtg_host.send8({own_addr, 1'h0}, ack);
        repeat (CONN_MIN_CYC) @(negedge clk);
    endtask
    initial begin
        repeat (12) @(negedge clk);
        rst_n = 1'h1;
        check({cmd_open_q, sys_reset_req_q, scl_oe, sda_oe, addressed, scl_o, sda_o}, 0);
        u_ibtg_host.start();
        u_ibtg_host.send8({7'h15, 1'h0}, ack);
        u_ibtg_host.stop();
        check({ack, cmd_open_q, stretch[7:0]}, 10'h200);
        open_frame();
        check(ack, 0);
        check(stretch, STRETCH_CYC);
        check(cmd_open_q, 1);
        foreach (rows[i]) begin
            got_rx = 1'h0;
            u_ibtg_host.send8(rows[i].data, ack);
            repeat (4) @(negedge clk);
            check({ack, got_rx, rx_data_q}, {rows[i].ack, 1'h1, rows[i].data});
        end
        check(dones, 5);
        wait_pulse(n);
        check(n >= TO - 16 && n <= TO + 4, 1);
        check(cmd_open_q, 0);
        u_ibtg_host.stop();
        n = pulses;
        open_frame();
        u_ibtg_host.stop();
        // The gap runs from the stop to the end of the next address byte, start and byte included.
        repeat (TO - 300) @(negedge clk);
        open_frame();
        u_ibtg_host.send8(8'h5A, ack);
        u_ibtg_host.stop();
        erase_busy = 1'h1;
        repeat (2 * TO) @(negedge clk);
        erase_busy = 1'h0;
        check(pulses - n, 0);
        check(cmd_open_q, 1);
        cmd_done = 1'h1;
        @(negedge clk);
        cmd_done = 1'h0;
        repeat (2 * TO) @(negedge clk);
        check(pulses - n, 0);
        check(cmd_open_q, 0);
        // A read frame: the address is acknowledged, read bytes are not.
        u_ibtg_host.start();
        u_ibtg_host.send8({own_addr, 1'h1}, ack);
        repeat (CONN_MIN_CYC) @(negedge clk);
        check({ack, rw_q, addressed, cmd_open_q}, 4'h7);
        got_rx = 1'h0;
        u_ibtg_host.send8(8'hFF, ack);
        repeat (4) @(negedge clk);
        check({ack, got_rx, rw_q, addressed}, 4'hB);
        u_ibtg_host.stop();
        open_frame();
        u_ibtg_host.stop();
        wait_pulse(n);
        check(n >= TO - 16 && n <= TO + 4, 1);
        complete_run();
    end
endmodule // ibtg_guard_tb

// file: ibtg_host.sv
`timescale 1ns/1ns
module ibtg_host (
    input wire logic clk, // Core clock.
    input ibtg_pkg::ibtg_pins_t bus_i, // Wire levels.
    output ibtg_pkg::ibtg_pins_t drv_o // Host drive, 1 releases.
);
    import ibtg_pkg::*;
    localparam int HALF = 8;
    initial drv_o = '1;
    task automatic tick(input int n);
        repeat (n) @(negedge clk);
    endtask
    // A stretched clock holds the host until the wire really rises, for up to 100 cycles.
    task automatic rise_scl();
        int w;
        w = 0;
        drv_o.scl = 1'h1;
        while (bus_i.scl !== 1'h1 && w < 100) begin
            tick(1);
            w++;
        end
    endtask
    task automatic bit_io(input logic b, output logic r);
        drv_o.sda = b;
        tick(HALF);
        rise_scl();
        tick(HALF);
        r = bus_i.sda;
        drv_o.scl = 1'h0;
        tick(2);
    endtask
    task automatic send8(input logic [7:0] d, output logic ack);
        logic r;
        for (int i = 7; i >= 0; i--) begin
            bit_io(d[i], r);
        end
        bit_io(1'h1, ack);
    endtask
    task automatic start();
        drv_o = '1;
        tick(HALF);
        drv_o.sda = 1'h0;
        tick(HALF);
        drv_o.scl = 1'h0;
        tick(2);
    endtask
    task automatic stop();
        drv_o.sda = 1'h0;
        tick(HALF);
        rise_scl();
        tick(HALF);
        drv_o.sda = 1'h1;
        tick(HALF);
    endtask
endmodule // ibtg_host

// file: ibtg_pkg.sv
package ibtg_pkg;

    // Core clock.
    localparam int unsigned CLK_HZ = 20_000_000;
    localparam int unsigned CLK_PERIOD_NS = 50;

    // Longest clock stretch after the address byte, 0.0025 ms, held here in ns.
    localparam int unsigned STRETCH_MAX_NS = 2500;
    localparam int unsigned STRETCH_CYC = (STRETCH_MAX_NS / CLK_PERIOD_NS < 1) ? 1 : STRETCH_MAX_NS / CLK_PERIOD_NS;

    // Least connection interval the host waits, 0.0250 ms, held here in ns.
    localparam int unsigned CONN_MIN_NS = 25000;
    localparam int unsigned CONN_MIN_CYC = (CONN_MIN_NS + CLK_PERIOD_NS - 1) / CLK_PERIOD_NS;

    // Inactivity timeout inside one command, in ms.
    localparam int unsigned TIMEOUT_MS = 1000;
    localparam int unsigned TIMEOUT_CYC = TIMEOUT_MS * (CLK_HZ / 1000);

    localparam int unsigned STRETCH_W = 8;
    localparam int unsigned TMO_W = 32;

    // Bit counter positions within one byte on the bus.
    localparam logic [3:0] BIT_ZERO = 4'h0;
    localparam logic [3:0] BIT_LAST_DATA = 4'h8;
    localparam logic [3:0] BIT_ACK = 4'h9;

    // Reset values.
    localparam logic [7:0] SHIFT_RST = 8'h00;
    localparam logic PIN_IDLE = 1'b1;

    typedef struct packed {
        logic scl;
        logic sda;
    } ibtg_pins_t;

    typedef enum logic [2:0] {
        IDLE,
        ADDR,
        HOLD,
        DATA,
        SKIP
    } ibtg_state_t;

endpackage

// file: ibtg_sync.sv
`timescale 1ns/1ns
module ibtg_sync (
    input wire logic clk, // Core clock.
    input wire logic rst_n, // Synchronous reset, active low.
    input ibtg_pkg::ibtg_pins_t pin_i, // Raw bus pins.
    output ibtg_pkg::ibtg_pins_t pin_o // Settled pin levels.
);
    import ibtg_pkg::*;

    ibtg_pins_t s1_q, s2_q, s3_q, filt_q;
    ibtg_pins_t s1_d, s2_d, s3_d, filt_d;

    // A level is taken only once the second and third stages agree.
    always_comb begin
        s1_d = pin_i;
        s2_d = s1_q;
        s3_d = s2_q;
        filt_d = filt_q;
        if (s2_q.scl == s3_q.scl) begin
            filt_d.scl = s3_q.scl;
        end
        if (s2_q.sda == s3_q.sda) begin
            filt_d.sda = s3_q.sda;
        end
    end

    always_ff @(posedge clk) begin
        if (!rst_n) begin
            s1_q <= '{scl: PIN_IDLE, sda: PIN_IDLE};
            s2_q <= '{scl: PIN_IDLE, sda: PIN_IDLE};
            s3_q <= '{scl: PIN_IDLE, sda: PIN_IDLE};
            filt_q <= '{scl: PIN_IDLE, sda: PIN_IDLE};
        end else begin
            s1_q <= s1_d;
            s2_q <= s2_d;
            s3_q <= s3_d;
            filt_q <= filt_d;
        end
    end

    assign pin_o = filt_q;

endmodule // ibtg_sync
